/* tmr_pkg.sv */
// constants, register map and field layouts of the timer block
// shared by the timer top, its prescaler and its testbench
package tmr_pkg;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 8;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OUTCTL = 8'h04;
  localparam logic [7:0] OFF_PRESC  = 8'h08;
  localparam logic [7:0] OFF_CMP    = 8'h0c;
  localparam logic [7:0] OFF_COUNT  = 8'h10;
  localparam logic [7:0] OFF_CAP0   = 8'h14;
  localparam logic [7:0] OFF_CAP1   = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // valid edge selection codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    logic pin_out;    // shared pin drives timer output
    logic cap_en;     // capture on primary edge
    logic edge_count; // primary edge is the count clock
    logic oneshot;    // one-shot pulse output mode
    logic run;        // counter operation enable
  } ctrl_s;

  typedef struct packed {
    logic toe;  // timer output enable
    logic lvs;  // output level set
    logic lvr;  // output level reset
    logic trig; // one-shot trigger
  } outctl_s;

  typedef struct packed {
    logic [1:0] edge1_sel;
    logic [1:0] edge0_sel;
    logic [1:0] div_sel;
  } presc_s;

  typedef struct packed {
    logic os_act;
    logic lvl;
    logic in1_lvl;
    logic in0_lvl;
  } stat_s;

  localparam ctrl_s       CTRL_RST  = '0;
  localparam presc_s      PRESC_RST = '0;
  localparam logic [15:0] CMP_RST   = 16'hffff;

  // divider mask per prescaler selection: 1, 4, 16, 64
  function automatic logic [5:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 6'h00;
      2'h1:    div_mask = 6'h03;
      2'h2:    div_mask = 6'h0f;
      default: div_mask = 6'h3f;
    endcase
  endfunction
endpackage

/* count_prescaler.sv */
// free-running prescaler that makes the count clock tick
// assumes one clock domain; tick is high for one cycle in each division period, so always high at divide 1
`timescale 1ns/1ps
module count_prescaler (
  input  wire logic       aclk,    // clock
  input  wire logic       aresetn, // sync reset, low
  input  wire logic [1:0] div_sel, // division select
  output logic            tick     // count clock pulse
);
  logic [5:0] div_r;
  logic       tick_r;
  wire  [5:0] mask_w = tmr_pkg::div_mask(div_sel);

  assign tick = tick_r;

  // runs even while stopped so filters keep sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r  <= 6'h00;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_r + 6'h01;
      tick_r <= ((div_r & mask_w) == mask_w);
    end
  end
endmodule

/* edge_filter.sv */
// two-sample noise filter and valid edge detector for one pin
// pin is asynchronous; smp selects the sampling clock enable
`timescale 1ns/1ps
module edge_filter (
  input  wire logic       aclk,    // clock
  input  wire logic       aresetn, // sync reset, low
  input  wire logic       pin,     // raw pin level
  input  wire logic       smp,     // sampling strobe
  input  wire logic       en,      // counter operation on
  input  wire logic [1:0] sel,     // valid edge select
  output logic            lvl,     // filtered level
  output logic            edge_o   // valid edge pulse
);
  logic meta_r, sync_r, s1_r, s2_r, prev_r, edge_r;

  // two successive equal samples qualify a level
  wire match_w = (s1_r == s2_r);
  wire chg_w   = en && smp && match_w && (s2_r != prev_r);
  wire rise_w  = chg_w && s2_r;
  wire fall_w  = chg_w && !s2_r;

  assign lvl    = prev_r;
  assign edge_o = edge_r;

  // prev only follows while enabled: a stop freezes the old level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      prev_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      if (smp) begin
        s1_r <= sync_r;
        s2_r <= s1_r;
      end
      if (en && smp && match_w)
        prev_r <= s2_r;
      edge_r <= (rise_w && sel[0]) || (fall_w && sel[1]);
    end
  end

  filt_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_r |-> $past(smp && match_w && en))
    else $error("edge reported without two matching samples");
  rise_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && smp && match_w && s2_r && !prev_r && sel[0]) |=> edge_r)
    else $error("rising level change at enable not reported");
  fall_det_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (en && smp && match_w && !s2_r && prev_r && sel[1]) |=> edge_r)
    else $error("falling level change at enable not reported");
  edge_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_r |-> ($past(s2_r) ? $past(sel[0]) : $past(sel[1])))
    else $error("edge reported for an unselected direction");
endmodule

/* timer_oneshot_capture.sv */
// timer/event counter with one-shot output, two captures and AXI4-Lite
// assumes one clock aclk; pins are asynchronous and filtered inside
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// What this block does
// - level bits accepted singly once output enabled
// - reset with high input gives rising edge
// - stopped high, enabled low gives falling edge
// - stopped low, enabled high gives rising edge
// - filter samples on aclk or count clock
// - capture needs two matching filtered samples
// - shared pin is capture input or output
// - one-shot trigger always reads zero
// - level set and reset read zero
module timer_oneshot_capture #(
  parameter int W = tmr_pkg::CNT_W
) (
  input  wire logic        aclk,               // clock, 40 MHz
  input  wire logic        aresetn,            // sync reset, low
  input  wire logic [7:0]  awaddr,             // write address
  input  wire logic        awvalid,            // write address valid
  output logic             awready,            // write address ready
  input  wire logic [31:0] wdata,              // write data
  input  wire logic [3:0]  wstrb,              // write strobes
  input  wire logic        wvalid,             // write data valid
  output logic             wready,             // write data ready
  output logic [1:0]       bresp,              // write response
  output logic             bvalid,             // write response valid
  input  wire logic        bready,             // write response ready
  input  wire logic [7:0]  araddr,             // read address
  input  wire logic        arvalid,            // read address valid
  output logic             arready,            // read address ready
  output logic [31:0]      rdata,              // read data
  output logic [1:0]       rresp,              // read response
  output logic             rvalid,             // read data valid
  input  wire logic        rready,             // read data ready
  input  wire logic        edge_input_primary, // primary edge input
  input  wire logic        shared_port_pin_i,  // shared pin level in
  output logic             shared_port_pin_o,  // timer output level
  output logic             shared_port_pin_oe  // timer output drive
);
  typedef enum logic {OS_IDLE, OS_PULSE} os_state_e;

  // bus side state
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        aw_have_r, w_have_r;
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // timer state
  tmr_pkg::ctrl_s  ctrl_r;
  tmr_pkg::presc_s presc_r;
  logic [W-1:0]    cmp_r, count_r, cap0_r, cap1_r;
  logic            toe_r, lvl_r, pin_o_r, pin_oe_r;
  os_state_e       os_r;

  // sub-block outputs
  logic            presc_tick, edge0, edge1, lvl0, lvl1;

  // write channel handshake
  wire aw_take = awvalid && awready_r;
  wire w_take  = wvalid && wready_r;
  wire do_wr   = aw_have_r && w_have_r && !bvalid_r;
  wire aw_have_nxt = (aw_have_r || aw_take) && !do_wr;
  wire w_have_nxt  = (w_have_r || w_take) && !do_wr;

  // write address decode
  wire hit_ctrl   = (aw_addr_r == tmr_pkg::OFF_CTRL);
  wire hit_outctl = (aw_addr_r == tmr_pkg::OFF_OUTCTL);
  wire hit_presc  = (aw_addr_r == tmr_pkg::OFF_PRESC);
  wire hit_cmp    = (aw_addr_r == tmr_pkg::OFF_CMP);
  wire hit_ro     = (aw_addr_r == tmr_pkg::OFF_COUNT) ||
                    (aw_addr_r == tmr_pkg::OFF_CAP0) ||
                    (aw_addr_r == tmr_pkg::OFF_CAP1) ||
                    (aw_addr_r == tmr_pkg::OFF_STAT);
  wire wr_ok = hit_ctrl || hit_outctl || hit_presc || hit_cmp || hit_ro;

  // control bits only need the low byte lane
  wire wr_ctrl   = do_wr && hit_ctrl && w_strb_r[0];
  wire wr_outctl = do_wr && hit_outctl && w_strb_r[0];
  wire wr_presc  = do_wr && hit_presc && w_strb_r[0];
  wire wr_cmp    = do_wr && hit_cmp;
  wire tmr_pkg::outctl_s oc_w =
    tmr_pkg::outctl_s'(w_data_r[$bits(tmr_pkg::outctl_s)-1:0]);

  // merge compare bytes under their strobes
  function automatic logic [W-1:0] merge_bytes(input logic [W-1:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0]  s);
    logic [31:0] m;
    m = 32'(old);
    for (int i = 0; i < 4; i++)
      if (s[i]) m[i*8 +: 8] = d[i*8 +: 8];
    merge_bytes = m[W-1:0];
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= !aw_have_nxt;
      wready_r  <= !w_have_nxt;
      if (aw_take) aw_addr_r <= awaddr;
      if (w_take) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
    end
  end

  // write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= tmr_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel: one read in flight, data registered
  wire ar_take   = arvalid && arready_r;
  wire rvalid_nx = ar_take || (rvalid_r && !rready);
  wire tmr_pkg::stat_s stat_w = '{os_act: (os_r == OS_PULSE), lvl: lvl_r,
                                  in1_lvl: lvl1, in0_lvl: lvl0};
  wire tmr_pkg::outctl_s oc_rd = '{toe: toe_r, lvs: 1'b0, lvr: 1'b0,
                                   trig: 1'b0};
  logic [31:0] rd_nxt;
  logic        rd_err;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_err = 1'b0;
    case (araddr)
      tmr_pkg::OFF_CTRL:   rd_nxt = 32'(ctrl_r);
      tmr_pkg::OFF_OUTCTL: rd_nxt = 32'(oc_rd);
      tmr_pkg::OFF_PRESC:  rd_nxt = 32'(presc_r);
      tmr_pkg::OFF_CMP:    rd_nxt = 32'(cmp_r);
      tmr_pkg::OFF_COUNT:  rd_nxt = 32'(count_r);
      tmr_pkg::OFF_CAP0:   rd_nxt = 32'(cap0_r);
      tmr_pkg::OFF_CAP1:   rd_nxt = 32'(cap1_r);
      tmr_pkg::OFF_STAT:   rd_nxt = 32'(stat_w);
      default:             rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= tmr_pkg::RESP_OKAY;
    end else begin
      rvalid_r  <= rvalid_nx;
      arready_r <= !rvalid_nx;
      if (ar_take) begin
        rdata_r <= rd_nxt;
        rresp_r <= rd_err ? tmr_pkg::RESP_SLVERR : tmr_pkg::RESP_OKAY;
      end
    end
  end

  // prescaler-selected count clock
  count_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div_sel (presc_r.div_sel),
    .tick    (presc_tick)
  );

  // edge counting samples on aclk, capture use on the count clock
  wire smp0 = ctrl_r.edge_count ? 1'b1 : presc_tick;
  // raw pin goes straight to the synchroniser; pin_out gates the capture

  edge_filter u_filt0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (edge_input_primary),
    .smp     (smp0),
    .en      (ctrl_r.run),
    .sel     (presc_r.edge0_sel),
    .lvl     (lvl0),
    .edge_o  (edge0)
  );

  edge_filter u_filt1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (shared_port_pin_i),
    .smp     (presc_tick),
    .en      (ctrl_r.run),
    .sel     (presc_r.edge1_sel),
    .lvl     (lvl1),
    .edge_o  (edge1)
  );

  // counting, trigger and capture decisions
  wire cnt_tick = ctrl_r.run && (ctrl_r.edge_count ? edge0 : presc_tick);
  wire trig     = wr_outctl && oc_w.trig && ctrl_r.oneshot && ctrl_r.run;
  wire os_end   = (os_r == OS_PULSE) && cnt_tick && (count_r == cmp_r);
  wire cap0_ev  = edge0 && ctrl_r.cap_en && !ctrl_r.edge_count;
  wire cap1_ev  = edge1 && !ctrl_r.pin_out;
  wire lvl_ok   = oc_w.toe || toe_r;
  wire lv_set   = wr_outctl && lvl_ok && oc_w.lvs && !oc_w.lvr;
  wire lv_clr   = wr_outctl && lvl_ok && oc_w.lvr && !oc_w.lvs;

  // software registers; prescaler writes are taken as given
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r  <= tmr_pkg::CTRL_RST;
      presc_r <= tmr_pkg::PRESC_RST;
      cmp_r   <= W'(tmr_pkg::CMP_RST);
      toe_r   <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= tmr_pkg::ctrl_s'(w_data_r[$bits(tmr_pkg::ctrl_s)-1:0]);
      if (wr_presc)
        presc_r <= tmr_pkg::presc_s'(w_data_r[$bits(tmr_pkg::presc_s)-1:0]);
      if (wr_cmp) cmp_r <= merge_bytes(cmp_r, w_data_r, w_strb_r);
      if (wr_outctl) toe_r <= oc_w.toe;
    end
  end

  // counter, one-shot sequence and captures
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      cap0_r  <= '0;
      cap1_r  <= '0;
      os_r    <= OS_IDLE;
    end else begin
      if (trig) count_r <= '0;
      else if (cnt_tick) count_r <= count_r + W'(1);
      if (cap0_ev) cap0_r <= count_r;
      if (cap1_ev) cap1_r <= count_r;
      case (os_r)
        OS_IDLE:  if (trig) os_r <= OS_PULSE;
        OS_PULSE: if (!trig && (os_end || !ctrl_r.run)) os_r <= OS_IDLE; // retrigger wins
        default:  os_r <= OS_IDLE;
      endcase
    end
  end

  // output level: software set/clear beats the one-shot sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r    <= 1'b0;
      pin_o_r  <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      if (lv_set) lvl_r <= 1'b1;
      else if (lv_clr) lvl_r <= 1'b0;
      else if (trig) lvl_r <= 1'b1;
      else if (os_end) lvl_r <= 1'b0;
      pin_o_r  <= lvl_r && toe_r;
      pin_oe_r <= ctrl_r.pin_out;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
  assign shared_port_pin_o  = pin_o_r;
  assign shared_port_pin_oe = pin_oe_r;

  // helper: remembers which offset the pending read came from
  logic [7:0] rd_addr_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr_q <= 8'h00;
    else if (ar_take) rd_addr_q <= araddr;
  end

  trig_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_r && rd_addr_q == tmr_pkg::OFF_OUTCTL) |-> !rdata_r[0])
    else $error("trigger bit read back as one");
  level_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid_r && rd_addr_q == tmr_pkg::OFF_OUTCTL) |-> rdata_r[2:1] == 2'h0)
    else $error("level set or reset read back nonzero");
  level_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_outctl && toe_r && oc_w.toe && oc_w.lvs && !oc_w.lvr) |=> lvl_r ##1 pin_o_r)
    else $error("single level set not accepted with output enabled");
  level_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_outctl && toe_r && oc_w.lvr && !oc_w.lvs) |=> !lvl_r ##1 !pin_o_r)
    else $error("single level reset not accepted with output enabled");
  pin_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_r.pin_out) |-> $stable(cap1_r))
    else $error("second capture taken while pin is an output");
  count_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r.run && ctrl_r.edge_count && !edge0 && !trig) |=> $stable(count_r))
    else $error("edge count mode counted without a valid edge");

  cov_oneshot: cover property (@(posedge aclk) disable iff (!aresetn)
    trig ##[1:300] os_end);
  cov_cap0: cover property (@(posedge aclk) disable iff (!aresetn) cap0_ev);
  cov_cap1: cover property (@(posedge aclk) disable iff (!aresetn) cap1_ev);
  cov_rdwr: cover property (@(posedge aclk) disable iff (!aresetn)
    do_wr && ar_take);
endmodule

/* pin_model.sv */
// external pins facing the timer: primary edge source and the shared pin
// assumes the bench commands the levels; the shared wire is resolved here
`timescale 1ns/1ps
module pin_model (
  input  wire logic prim_cmd, // commanded primary level
  input  wire logic sec_cmd,  // commanded secondary level
  input  wire logic pin_o,    // timer output level
  input  wire logic pin_oe,   // timer drives the shared pin
  output logic      prim_pin, // primary edge input
  output logic      sec_wire  // shared pin as all parties see it
);
  // primary source follows the bench, no pull on this line
  assign prim_pin = prim_cmd;
  // source lets go of the shared pin while the timer drives it, so no fight
  assign sec_wire = pin_oe ? pin_o : sec_cmd;
endmodule

/* timer_oneshot_capture_tb.sv */
// self-checking bench for the timer: bus answers, edge counting,
// one-shot output and capture filtering; assumes design and pin_model
`timescale 1ns/1ps
module timer_oneshot_capture_tb;
  typedef struct packed {
    logic        is_rd; // read or write answer
    logic [1:0]  how;   // 0 exact, 1 nonzero, 2 data ignored
    logic [31:0] exp;   // expected data
    logic [1:0]  resp;  // expected response
  } note_s;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        prim_cmd, prim, sec_cmd, sec_wire, pin_o, pin_oe;
  logic [15:0] len;
  note_s       q[$];
  note_s       nt;
  int          err_count, checks_done, n, k, pulses;

  timer_oneshot_capture dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .edge_input_primary(prim), .shared_port_pin_i(sec_wire),
    .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe)
  );

  pin_model pins (
    .prim_cmd(prim_cmd), .sec_cmd(sec_cmd), .pin_o(pin_o), .pin_oe(pin_oe),
    .prim_pin(prim), .sec_wire(sec_wire)
  );

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled at the falling edge, where it already holds its
  // value for the next rising edge, to stay clear of flop races
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    logic ta, tw;
    q.push_back('{1'b0, 2'd2, 32'h0, r});
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (awvalid && awready);
      tw = tw | (wvalid && wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] how,
                    input logic [1:0] r);
    q.push_back('{1'b1, how, e, r});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready  <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge aclk);
  endtask

  task automatic wait_pin(input logic v, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge aclk);
      cnt++;
    end while (pin_o !== v && cnt < lim);
  endtask

  task automatic summarize;
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // answer watcher: oldest note against each answer taken
  always @(negedge aclk) begin
    if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
      nt = q.pop_front();
      cmp({31'h0, rvalid && rready}, {31'h0, nt.is_rd});
      if (rvalid && rready && nt.how == 2'd0) cmp(rdata, nt.exp);
      if (rvalid && rready && nt.how == 2'd1) cmp({31'h0, rdata != 32'h0}, 32'h1);
      cmp({30'h0, (rvalid && rready) ? rresp : bresp}, {30'h0, nt.resp});
    end
  end

  // watchdog: the sequence needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    prim_cmd = 1'b1;
    sec_cmd = 1'b0;
    err_count = 0;
    checks_done = 0;
    n = $urandom(32'h2e9afb73);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then an unmapped place both ways
    rd(tmr_pkg::OFF_CTRL, 32'h0, 2'd0, tmr_pkg::RESP_OKAY);
    rd(tmr_pkg::OFF_PRESC, 32'h0, 2'd0, tmr_pkg::RESP_OKAY);
    rd(tmr_pkg::OFF_CMP, 32'hffff, 2'd0, tmr_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, 2'd2, tmr_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, 4'hf, tmr_pkg::RESP_SLVERR);
    // primary high since reset: enabling with rising edge counts once
    wr(tmr_pkg::OFF_PRESC, 32'h04, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CTRL, 32'h05, 4'h1, tmr_pkg::RESP_OKAY);
    idle(12);
    rd(tmr_pkg::OFF_COUNT, 32'h1, 2'd0, tmr_pkg::RESP_OKAY);
    // stopped high, enabled low, falling edge selected
    wr(tmr_pkg::OFF_CTRL, 32'h00, 4'h1, tmr_pkg::RESP_OKAY);
    prim_cmd <= 1'b0;
    idle(12);
    wr(tmr_pkg::OFF_PRESC, 32'h08, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CTRL, 32'h05, 4'h1, tmr_pkg::RESP_OKAY);
    idle(12);
    rd(tmr_pkg::OFF_COUNT, 32'h2, 2'd0, tmr_pkg::RESP_OKAY);
    // stopped low, enabled high, both edges selected
    wr(tmr_pkg::OFF_CTRL, 32'h00, 4'h1, tmr_pkg::RESP_OKAY);
    prim_cmd <= 1'b1;
    idle(12);
    wr(tmr_pkg::OFF_PRESC, 32'h0c, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CTRL, 32'h05, 4'h1, tmr_pkg::RESP_OKAY);
    idle(12);
    rd(tmr_pkg::OFF_COUNT, 32'h3, 2'd0, tmr_pkg::RESP_OKAY);
    // random run of toggles, each an edge when both are selected
    pulses = $urandom_range(6, 2);
    for (k = 0; k < pulses; k++) begin
      prim_cmd <= ~prim_cmd;
      idle(12);
    end
    // one-cycle glitch must be filtered away
    prim_cmd <= ~prim_cmd;
    idle(1);
    prim_cmd <= ~prim_cmd;
    idle(12);
    rd(tmr_pkg::OFF_COUNT, 32'(3 + pulses), 2'd0, tmr_pkg::RESP_OKAY);
    // one-shot on the shared pin with a random length
    wr(tmr_pkg::OFF_CTRL, 32'h00, 4'h1, tmr_pkg::RESP_OKAY);
    len = 16'($urandom_range(20, 4));
    wr(tmr_pkg::OFF_PRESC, 32'h10, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CMP, {16'h0, len}, 4'h3, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CTRL, 32'h13, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_OUTCTL, 32'h08, 4'h1, tmr_pkg::RESP_OKAY);
    rd(tmr_pkg::OFF_CMP, {16'h0, len}, 2'd0, tmr_pkg::RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      wr(tmr_pkg::OFF_OUTCTL, 32'h09, 4'h1, tmr_pkg::RESP_OKAY);
      rd(tmr_pkg::OFF_OUTCTL, 32'h08, 2'd0, tmr_pkg::RESP_OKAY);
      wait_pin(1'b1, 20, n);
      cmp({31'h0, pin_o}, 32'h1);
      cmp({31'h0, pin_oe}, 32'h1);
      wait_pin(1'b0, 200, n);
      cmp({31'h0, n >= int'(len) - 4 && n <= int'(len) + 2}, 32'h1);
    end
    // the timer's own pulses on the shared pin are no capture input
    rd(tmr_pkg::OFF_CAP1, 32'h0, 2'd0, tmr_pkg::RESP_OKAY);
    // level set and reset one at a time once output is enabled
    wr(tmr_pkg::OFF_OUTCTL, 32'h0c, 4'h1, tmr_pkg::RESP_OKAY);
    wait_pin(1'b1, 10, n);
    cmp({31'h0, pin_o}, 32'h1);
    rd(tmr_pkg::OFF_OUTCTL, 32'h08, 2'd0, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_OUTCTL, 32'h0a, 4'h1, tmr_pkg::RESP_OKAY);
    wait_pin(1'b0, 10, n);
    cmp({31'h0, pin_o}, 32'h0);
    // captures on both inputs sample at the divided count clock
    wr(tmr_pkg::OFF_CTRL, 32'h00, 4'h1, tmr_pkg::RESP_OKAY);
    prim_cmd <= 1'b0;
    wr(tmr_pkg::OFF_OUTCTL, 32'h00, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_PRESC, 32'h17, 4'h1, tmr_pkg::RESP_OKAY);
    wr(tmr_pkg::OFF_CTRL, 32'h09, 4'h1, tmr_pkg::RESP_OKAY);
    @(negedge aclk);
    cmp({31'h0, pin_oe}, 32'h0);
    idle(1);
    // a pulse shorter than one tick spacing never gives two equal samples
    sec_cmd <= 1'b1;
    prim_cmd <= 1'b1;
    idle(40);
    sec_cmd <= 1'b0;
    prim_cmd <= 1'b0;
    idle(200);
    rd(tmr_pkg::OFF_CAP0, 32'h0, 2'd0, tmr_pkg::RESP_OKAY);
    rd(tmr_pkg::OFF_CAP1, 32'h0, 2'd0, tmr_pkg::RESP_OKAY);
    sec_cmd <= 1'b1;
    prim_cmd <= 1'b1;
    idle(400);
    rd(tmr_pkg::OFF_CAP0, 32'h0, 2'd1, tmr_pkg::RESP_OKAY);
    rd(tmr_pkg::OFF_CAP1, 32'h0, 2'd1, tmr_pkg::RESP_OKAY);
    idle(4);
    summarize();
  end
endmodule
